/* rtl/icx_chan.sv */
`timescale 1ns/1ns
`default_nettype none
`include "icx_regs.svh"
module icx_chan import icx_pkg::*; #(
  parameter int DEPTH = 4,
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // pin events and core state
  input wire logic rise,
  input wire logic fall,
  input wire logic halt,
  // control, time base, read strobe
  input wire icx_cap_ctrl_type ctrl,
  input wire logic [W-1:0] tb,
  input wire logic rd,
  // status
  output logic [W-1:0] rd_data_q,
  output logic not_empty,
  output logic ovf_q,
  output logic evt,
  output logic wake
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] wr_idx;
  logic [3:0] pre_q;
  logic [1:0] evc_q;
  logic blk_q, hit, cap, full, store, ovf_evt, rd_eff, off;

  assign off = ctrl.mode == `ICX_M_OFF;
  assign full = cnt_q == CW'(DEPTH);
  assign cap = hit && !halt && !blk_q;
  assign store = cap && !full;
  assign ovf_evt = cap && full && ctrl.mode != `ICX_M_EDGE;
  assign rd_eff = rd && cnt_q != '0;
  assign wr_idx = cnt_q - CW'(rd_eff);
  assign not_empty = cnt_q != '0;
  assign wake = rise && ctrl.mode == `ICX_M_WAKE;

  always_comb begin
    unique case (ctrl.mode)
      `ICX_M_EDGE: hit = rise || fall;
      `ICX_M_FALL: hit = fall;
      `ICX_M_RISE, `ICX_M_WAKE: hit = rise;
      `ICX_M_RISE4: hit = rise && pre_q[1:0] == 2'h3;
      `ICX_M_RISE16: hit = rise && pre_q == 4'hF;
      default: hit = 1'b0;
    endcase
  end

  // edge prescaler
  always_ff @(posedge core_clk) begin
    if (!nrst || off) begin
      pre_q <= 4'h0;
    end else if (rise && !halt && (ctrl.mode == `ICX_M_RISE4 || ctrl.mode == `ICX_M_RISE16)) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // fill level, overflow and lock-out
  always_ff @(posedge core_clk) begin
    if (!nrst || off) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + CW'(store) - CW'(rd_eff);
      if (ovf_evt) begin
        ovf_q <= 1'b1;
        blk_q <= 1'b1;
      end else if (cnt_q == CW'(1) && rd_eff) begin
        blk_q <= 1'b0;
      end
    end
  end

  // storage shifts toward slot 0 so the oldest value is always at the head
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (rd_eff && i < DEPTH - 1) begin
        mem_q[i] <= mem_q[i+1];
      end
      if (store && wr_idx == CW'(i)) begin
        mem_q[i] <= tb;
      end
    end
  end

  // an empty read returns a stale head value
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_data_q <= '0;
    end else if (rd) begin
      rd_data_q <= mem_q[0];
    end
  end

  // event counting toward the channel flag
  always_ff @(posedge core_clk) begin
    if (!nrst || off) begin
      evc_q <= 2'h0;
    end else if (store && ctrl.mode != `ICX_M_EDGE) begin
      evc_q <= (evc_q == ctrl.evsel) ? 2'h0 : evc_q + 2'h1;
    end
  end

  assign evt = (ctrl.mode == `ICX_M_EDGE) ? cap
             : (store && evc_q == ctrl.evsel) || (halt && wake);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_ovf_sets: assert property (cap && full && ctrl.mode != `ICX_M_EDGE && !rd |=> ovf_q && cnt_q == CW'(DEPTH)) else $error("overflow not flagged");
  a_lock_out: assert property (blk_q && cnt_q != '0 && !rd && !off |=> $stable(cnt_q)) else $error("capture taken after overflow");
  a_off_clear: assert property (off |=> pre_q == 4'h0 && cnt_q == '0) else $error("off did not clear");
  a_read_order: assert property (rd && cnt_q > CW'(1) |=> rd_data_q == $past(mem_q[0]) && mem_q[0] == $past(mem_q[1])) else $error("read order wrong");
  a_edge_no_ovf: assert property (ctrl.mode == `ICX_M_EDGE && !ovf_q |=> !ovf_q) else $error("overflow in every-edge mode");
  c_overflow: cover property (ovf_evt);
  c_every16: cover property (hit && ctrl.mode == `ICX_M_RISE16);
endmodule
`default_nettype wire

/* rtl/icx_pkg.sv */
`default_nettype none
package icx_pkg;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} icx_rd_state_type;
  typedef struct packed {
    logic sidl;
    logic tsel;
    logic [1:0] evsel;
    logic [2:0] mode;
  } icx_cap_ctrl_type;
endpackage
`default_nettype wire

/* rtl/icx_regs.svh */
`ifndef ICX_REGS_SVH
`define ICX_REGS_SVH
// register indices; byte address is four times the index
`define ICX_IDX_TIMER_LOW_COUNT 10'h106
`define ICX_IDX_HLD 10'h108
`define ICX_IDX_TIMER_HIGH_COUNT 10'h10A
`define ICX_IDX_PR2 10'h10C
`define ICX_IDX_PR3 10'h10E
`define ICX_IDX_TCON2 10'h110
`define ICX_IDX_TCON3 10'h112
`define ICX_IDX_INTERRUPT_FLAG_STATUS_REG0 10'h084
`define ICX_IDX_CFLG 10'h088
`define ICX_IDX_INTERRUPT_ENABLE_CTRL_REG0 10'h08C
`define ICX_IDX_CEN 10'h090
// capture page: buffer at 0x140 + 4n, control at 0x142 + 4n
`define ICX_CAP_PAGE 5'h0A
`define ICX_PR_RST 16'hFFFF
`define ICX_TCON_RST 16'h0000
`define ICX_TCON2_MASK 16'hA07A
`define ICX_TCON3_MASK 16'hA072
`define ICX_B_TON 15
`define ICX_B_HALT_IN_IDLE 13
`define ICX_B_GATED_ACCUMULATION_ENABLE 6
`define ICX_B_TCKPS 4
`define ICX_B_T32 3
`define ICX_B_TCS 1
`define ICX_B_TBIRQ 7
`define ICX_B_CSIDL 13
`define ICX_M_OFF 3'h0
`define ICX_M_EDGE 3'h1
`define ICX_M_FALL 3'h2
`define ICX_M_RISE 3'h3
`define ICX_M_RISE4 3'h4
`define ICX_M_RISE16 3'h5
`define ICX_M_WAKE 3'h7
`define ICX_PS_1 8'h00
`define ICX_PS_8 8'h07
`define ICX_PS_64 8'h3F
`define ICX_PS_256 8'hFF
`define ICX_RESP_OK 2'h0
`define ICX_RESP_ERR 2'h2
`endif

/* rtl/icx_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "icx_regs.svh"
module icx_top import icx_pkg::*; #(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // pins
  input wire logic [CHANNELS-1:0] cap_pin,
  input wire logic gate_clk_pin,
  input wire logic t3_clk_pin,
  // core power state
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  // requests
  output logic timebase_irq_q,
  output logic [CHANNELS-1:0] capture_irq_q,
  output logic wake_req_q
);
  localparam int GP = CHANNELS;
  localparam int T3P = CHANNELS + 1;

  logic [CHANNELS+1:0] pin_s1_q, pin_s2_q, pin_p_q, rise, fall;
  logic [15:0] t2_q, t3_q, hld_q, pr2_q, pr3_q, tcon2_q, tcon3_q;
  logic [15:0] bm, wd, rv;
  logic [7:0] ps2_q, ps3_q;
  logic timebase_interrupt_flag_q, timebase_interrupt_enable_q, tb_set;
  logic [CHANNELS-1:0] cflg_q, cen_q, cevt, cwake, cne, covf;
  logic [15:0] cbuf [CHANNELS];
  icx_cap_ctrl_type cctl_q [CHANNELS];
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q;
  logic [3:0] wstrb_q;
  logic [11:0] awaddr_q;
  logic aw_full_q, w_full_q, aw_full_d, w_full_d, wr_en, ar_hs, rok, rbuf_q;
  logic [9:0] widx, ridx;
  logic [2:0] rch_q;
  icx_rd_state_type st_q;
  logic wide, run2, run3, src2, src3, tick2, tick3, m32, clr2, clr3;
  logic we_cap;

  function automatic logic [15:0] mrg(input logic [15:0] o, input logic [15:0] m,
                                      input logic [15:0] d);
    return (o & ~m) | (d & m);
  endfunction

  function automatic logic [7:0] lim(input logic [1:0] sel);
    unique case (sel)
      2'h0: lim = `ICX_PS_1;
      2'h1: lim = `ICX_PS_8;
      2'h2: lim = `ICX_PS_64;
      2'h3: lim = `ICX_PS_256;
    endcase
  endfunction

  function automatic logic cap_page(input logic [9:0] i);
    return i[9:5] == `ICX_CAP_PAGE && !i[0] && int'(i[4:2]) < CHANNELS;
  endfunction

  function automatic logic mapped(input logic [9:0] i);
    return cap_page(i) || i == `ICX_IDX_TIMER_LOW_COUNT || i == `ICX_IDX_HLD || i == `ICX_IDX_TIMER_HIGH_COUNT
      || i == `ICX_IDX_PR2 || i == `ICX_IDX_PR3 || i == `ICX_IDX_TCON2
      || i == `ICX_IDX_TCON3 || i == `ICX_IDX_INTERRUPT_FLAG_STATUS_REG0 || i == `ICX_IDX_INTERRUPT_ENABLE_CTRL_REG0
      || i == `ICX_IDX_CFLG || i == `ICX_IDX_CEN;
  endfunction

  // pins are asynchronous: two flops, then a third for edge detection
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_p_q <= '0;
    end else begin
      pin_s1_q <= {t3_clk_pin, gate_clk_pin, cap_pin};
      pin_s2_q <= pin_s1_q;
      pin_p_q <= pin_s2_q;
    end
  end
  assign rise = pin_s2_q & ~pin_p_q;
  assign fall = ~pin_s2_q & pin_p_q;

  // write channel: address and data accepted in either order
  assign wr_en = aw_full_q && w_full_q && !bvalid_q;
  assign aw_full_d = (awvalid && awready_q) || (aw_full_q && !wr_en);
  assign w_full_d = (wvalid && wready_q) || (w_full_q && !wr_en);
  assign widx = awaddr_q[11:2];
  assign bm = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wd = wdata_q[15:0];
  assign we_cap = wr_en && cap_page(widx) && widx[1];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ICX_RESP_OK;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= !aw_full_d;
      wready_q <= !w_full_d;
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(widx) ? `ICX_RESP_OK : `ICX_RESP_ERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready_q) awaddr_q <= awaddr;
      if (wvalid && wready_q) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // timer pair; the second pair does not exist here, so capture sees only this one
  assign wide = tcon2_q[`ICX_B_T32];
  assign run2 = tcon2_q[`ICX_B_TON] && !cpu_sleep && !(cpu_idle && tcon2_q[`ICX_B_HALT_IN_IDLE]);
  assign run3 = tcon3_q[`ICX_B_TON] && !cpu_sleep && !(cpu_idle && tcon3_q[`ICX_B_HALT_IN_IDLE]);
  assign src2 = tcon2_q[`ICX_B_TCS] ? rise[GP] : (tcon2_q[`ICX_B_GATED_ACCUMULATION_ENABLE] ? pin_s2_q[GP] : 1'b1);
  assign src3 = tcon3_q[`ICX_B_TCS] ? rise[T3P] : (tcon3_q[`ICX_B_GATED_ACCUMULATION_ENABLE] ? pin_s2_q[T3P] : 1'b1);
  assign tick2 = run2 && src2 && ps2_q == lim(tcon2_q[`ICX_B_TCKPS+:2]);
  assign tick3 = !wide && run3 && src3 && ps3_q == lim(tcon3_q[`ICX_B_TCKPS+:2]);
  assign m32 = {t3_q, t2_q} == {pr3_q, pr2_q};
  assign clr2 = wr_en && (widx == `ICX_IDX_TIMER_LOW_COUNT || widx == `ICX_IDX_TCON2);
  assign clr3 = wr_en && (widx == `ICX_IDX_TIMER_HIGH_COUNT || widx == `ICX_IDX_TCON3);

  always_ff @(posedge core_clk) begin
    if (!nrst || clr2) ps2_q <= 8'h00;
    else if (run2 && src2) ps2_q <= tick2 ? 8'h00 : ps2_q + 8'h01;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || clr3) ps3_q <= 8'h00;
    else if (!wide && run3 && src3) ps3_q <= tick3 ? 8'h00 : ps3_q + 8'h01;
  end

  // counts; a bus write wins over a tick in the same cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      t2_q <= 16'h0000;
      t3_q <= 16'h0000;
    end else begin
      if (wide && tick2) begin
        {t3_q, t2_q} <= m32 ? 32'h0000_0000 : {t3_q, t2_q} + 32'h0000_0001;
      end else begin
        if (!wide && tick2) t2_q <= (t2_q == pr2_q) ? 16'h0000 : t2_q + 16'h0001;
        if (tick3) t3_q <= (t3_q == pr3_q) ? 16'h0000 : t3_q + 16'h0001;
      end
      if (wr_en && widx == `ICX_IDX_TIMER_LOW_COUNT) begin
        t2_q <= mrg(t2_q, bm, wd);
        if (wide) t3_q <= hld_q;
      end
      if (wr_en && widx == `ICX_IDX_TIMER_HIGH_COUNT) t3_q <= mrg(t3_q, bm, wd);
    end
  end

  // reading the low count latches the high count for a coherent 32-bit view
  always_ff @(posedge core_clk) begin
    if (!nrst) hld_q <= 16'h0000;
    else if (ar_hs && ridx == `ICX_IDX_TIMER_LOW_COUNT) hld_q <= t3_q;
    else if (wr_en && widx == `ICX_IDX_HLD) hld_q <= mrg(hld_q, bm, wd);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pr2_q <= `ICX_PR_RST;
      pr3_q <= `ICX_PR_RST;
      tcon2_q <= `ICX_TCON_RST;
      tcon3_q <= `ICX_TCON_RST;
    end else if (wr_en) begin
      if (widx == `ICX_IDX_PR2) pr2_q <= mrg(pr2_q, bm, wd);
      if (widx == `ICX_IDX_PR3) pr3_q <= mrg(pr3_q, bm, wd);
      if (widx == `ICX_IDX_TCON2) tcon2_q <= mrg(tcon2_q, bm, wd) & `ICX_TCON2_MASK;
      if (widx == `ICX_IDX_TCON3) tcon3_q <= mrg(tcon3_q, bm, wd) & `ICX_TCON3_MASK;
    end
  end

  // timebase flag: a hardware set wins over a software clear in the same cycle
  assign tb_set = (wide && tick2 && m32) || (tick3 && t3_q == pr3_q)
    || (wide && tcon2_q[`ICX_B_TON] && tcon2_q[`ICX_B_GATED_ACCUMULATION_ENABLE] && !tcon2_q[`ICX_B_TCS]
        && fall[GP]);
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      timebase_interrupt_flag_q <= 1'b0;
      timebase_interrupt_enable_q <= 1'b0;
    end else begin
      if (tb_set) timebase_interrupt_flag_q <= 1'b1;
      else if (wr_en && widx == `ICX_IDX_INTERRUPT_FLAG_STATUS_REG0 && wstrb_q[0]) timebase_interrupt_flag_q <= wd[`ICX_B_TBIRQ];
      if (wr_en && widx == `ICX_IDX_INTERRUPT_ENABLE_CTRL_REG0 && wstrb_q[0]) timebase_interrupt_enable_q <= wd[`ICX_B_TBIRQ];
    end
  end

  // capture channel control, flags and enables
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < CHANNELS; i++) cctl_q[i] <= '0;
    end else if (we_cap) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (widx[4:2] == 3'(i)) begin
          if (wstrb_q[1]) cctl_q[i].sidl <= wd[`ICX_B_CSIDL];
          if (wstrb_q[0]) {cctl_q[i].tsel, cctl_q[i].evsel, cctl_q[i].mode} <= {wd[7:5], wd[2:0]};
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cflg_q <= '0;
      cen_q <= '0;
    end else begin
      if (wr_en && widx == `ICX_IDX_CFLG && wstrb_q[0]) cflg_q <= cevt | wdata_q[CHANNELS-1:0];
      else cflg_q <= cflg_q | cevt;
      if (wr_en && widx == `ICX_IDX_CEN && wstrb_q[0]) cen_q <= wdata_q[CHANNELS-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      timebase_irq_q <= 1'b0;
      capture_irq_q <= '0;
      wake_req_q <= 1'b0;
    end else begin
      timebase_irq_q <= timebase_interrupt_flag_q && timebase_interrupt_enable_q;
      capture_irq_q <= cflg_q & cen_q;
      wake_req_q <= |(cwake & cen_q);
    end
  end

  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    icx_chan u_chan (
      .core_clk(core_clk),
      .nrst(nrst),
      .rise(rise[g]),
      .fall(fall[g]),
      .halt(cpu_sleep || (cpu_idle && cctl_q[g].sidl)),
      .ctrl(cctl_q[g]),
      .tb(cctl_q[g].tsel ? t2_q : t3_q),
      .rd(ar_hs && cap_page(ridx) && !ridx[1] && ridx[4:2] == 3'(g)),
      .rd_data_q(cbuf[g]),
      .not_empty(cne[g]),
      .ovf_q(covf[g]),
      .evt(cevt[g]),
      .wake(cwake[g])
    );
    // checked per channel so any channel the bench picks exercises it
    a_wake_req: assert property (@(posedge core_clk) disable iff (!nrst)
      rise[g] && cctl_q[g].mode == `ICX_M_WAKE && cen_q[g] |=> wake_req_q)
      else $error("wake missing");
  end

  // read path: registers sampled at address acceptance, buffer one cycle later
  assign ar_hs = arvalid && arready_q;
  assign ridx = araddr[11:2];
  assign rok = mapped(ridx);

  always_comb begin
    rv = 16'h0000;
    if (cap_page(ridx)) begin
      if (ridx[1]) begin
        rv = {2'h0, cctl_q[ridx[4:2]].sidl, 5'h00, cctl_q[ridx[4:2]].tsel,
              cctl_q[ridx[4:2]].evsel, covf[ridx[4:2]], cne[ridx[4:2]],
              cctl_q[ridx[4:2]].mode};
      end
    end else begin
      case (ridx)
        `ICX_IDX_TIMER_LOW_COUNT: rv = t2_q;
        `ICX_IDX_HLD: rv = hld_q;
        `ICX_IDX_TIMER_HIGH_COUNT: rv = t3_q;
        `ICX_IDX_PR2: rv = pr2_q;
        `ICX_IDX_PR3: rv = pr3_q;
        `ICX_IDX_TCON2: rv = tcon2_q;
        `ICX_IDX_TCON3: rv = tcon3_q;
        `ICX_IDX_INTERRUPT_FLAG_STATUS_REG0: rv = {8'h00, timebase_interrupt_flag_q, 7'h00};
        `ICX_IDX_INTERRUPT_ENABLE_CTRL_REG0: rv = {8'h00, timebase_interrupt_enable_q, 7'h00};
        `ICX_IDX_CFLG: rv = 16'(cflg_q);
        `ICX_IDX_CEN: rv = 16'(cen_q);
        default: rv = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_q <= RD_IDLE;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ICX_RESP_OK;
      rbuf_q <= 1'b0;
      rch_q <= 3'h0;
    end else begin
      unique case (st_q)
        RD_IDLE: begin
          arready_q <= !ar_hs;
          if (ar_hs) begin
            st_q <= RD_WAIT;
            rdata_q <= {16'h0000, rv};
            rresp_q <= rok ? `ICX_RESP_OK : `ICX_RESP_ERR;
            rbuf_q <= cap_page(ridx) && !ridx[1];
            rch_q <= ridx[4:2];
          end
        end
        RD_WAIT: begin
          if (rbuf_q) rdata_q <= {16'h0000, cbuf[rch_q]};
          rvalid_q <= 1'b1;
          st_q <= RD_RESP;
        end
        RD_RESP: begin
          if (rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
            st_q <= RD_IDLE;
          end
        end
      endcase
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_sleep_stops: assert property (cpu_sleep && !wr_en |=> $stable(t2_q) && $stable(t3_q)) else $error("timer moved in sleep");
  a_wide_match: assert property (wide && tick2 && m32 && !wr_en |=> timebase_interrupt_flag_q && t2_q == 16'h0000 && t3_q == 16'h0000) else $error("wide match missed");
  a_flag_sticky: assert property (timebase_interrupt_flag_q && !(wr_en && widx == `ICX_IDX_INTERRUPT_FLAG_STATUS_REG0) |=> timebase_interrupt_flag_q) else $error("flag cleared by hardware");
  a_irq_enable: assert property (!timebase_interrupt_enable_q ##1 !timebase_interrupt_enable_q |-> !timebase_irq_q) else $error("request while disabled");
  a_read_lat: assert property (ar_hs |=> !rvalid_q ##1 rvalid_q) else $error("read answer timing wrong");
  c_wide_match: cover property (wide && tick2 && m32);
  c_wake_sleep: cover property (cpu_sleep && wake_req_q);
endmodule
`default_nettype wire

/* sim/icx_pin_drv.sv */
`timescale 1ns/1ns
`default_nettype none
// far-side pin source: equal high and low times, fast or slow
module icx_pin_drv (
  // clock
  input wire logic core_clk,
  // request
  input wire logic go,
  input wire logic slow,
  input wire logic [7:0] sel,
  input wire logic [5:0] pulses,
  // pins and status
  output logic [7:0] pins,
  output logic busy
);
  int n;
  initial begin
    pins = 8'h00;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (go) begin
        busy <= 1'b1;
        for (n = 0; n < pulses; n++) begin
          pins <= sel;
          repeat (slow ? 9 : 4) @(posedge core_clk);
          pins <= 8'h00;
          repeat (slow ? 9 : 4) @(posedge core_clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/input_capture_with_timebase_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "icx_regs.svh"
module input_capture_with_timebase_tb_top;
  logic core_clk, nrst, awvalid, wvalid, bready, arvalid, rready, cpu_sleep, go, slow, gate;
  logic awready, wready, bvalid, arready, rvalid, timebase_irq_q, wake_req_q, busy, wake_seen;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [7:0] cap_pin, sel, capture_irq_q;
  logic [5:0] pulses;
  logic [15:0] prev;
  logic [2:0] m;
  logic [2:0] ml [5] = '{`ICX_M_FALL, `ICX_M_RISE, `ICX_M_RISE4, `ICX_M_RISE16, `ICX_M_EDGE};
  int fails, compares, i, j, k, c, e;

  icx_top #(.CHANNELS(8)) DUT (.core_clk, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .cap_pin, .gate_clk_pin(gate), .t3_clk_pin(1'b0), .cpu_sleep,
    .cpu_idle(1'b0), .timebase_irq_q, .capture_irq_q, .wake_req_q);
  icx_pin_drv PIN (.core_clk, .go, .slow, .sel, .pulses, .pins(cap_pin), .busy);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (wake_req_q === 1'b1) wake_seen <= 1'b1;

  function automatic logic [31:0] nxt();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  function automatic logic [11:0] cr(int ch, int o);
    return {10'(10'h140 + 4 * ch + o), 2'b00};
  endfunction
  function automatic int caps(logic [2:0] md, int p);
    case (md)
      `ICX_M_EDGE: return 2 * p;
      `ICX_M_RISE4: return p / 4;
      `ICX_M_RISE16: return p / 16;
      default: return p;
    endcase
  endfunction
  // spacing between stored captures, in half periods of the pin; every-16 mode gets 2 here, not 32
  function automatic int step(logic [2:0] md);
    return (md == `ICX_M_EDGE) ? 1 : (md == `ICX_M_RISE4) ? 8 : 2;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang();
    fails++;
    wrap_up();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      fails++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    int n;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    // bready stays high, so a following call re-drives it to the same level in the same step
    wr_r = bresp;
    if (n == 50) hang();
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd_q = rdata;
    rd_r = rresp;
    if (n == 50) hang();
  endtask
  // fixed wait after the burst covers sync and edge detect
  task automatic pulse(input int ch, input int p);
    int n;
    sel <= 8'h01 << ch;
    pulses <= 6'(p);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    for (n = 0; n < 800; n++) begin
      @(posedge core_clk);
      if (!busy) break;
    end
    repeat (5) @(posedge core_clk);
    if (n == 800) hang();
  endtask

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, cpu_sleep, go, slow, gate} = 10'h000;
    {awaddr, araddr, wdata, wstrb, sel, pulses} = '0;
    rnd = 32'h24FD;
    fails = 0;
    compares = 0;
    wake_seen = 1'b0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd({`ICX_IDX_PR2, 2'b00});
    chk("period_low", rd_q, 32'h0000FFFF);
    rd({`ICX_IDX_PR3, 2'b00});
    chk("period_high", rd_q, 32'h0000FFFF);
    rd({`ICX_IDX_TCON3, 2'b00});
    chk("timer_high_control", rd_q, 32'h00000000);
    rd(12'hFFC);
    chk("unmapped resp", rd_r, `ICX_RESP_ERR);
    wr(12'hFFC, 16'h0000);
    chk("unmapped write resp", wr_r, `ICX_RESP_ERR);
    wr({`ICX_IDX_TCON2, 2'b00}, 16'h8000);
    for (i = 0; i < 5; i++) begin
      c = nxt() & 32'h7;
      slow <= 1'(nxt() & 32'h1);
      m = ml[i];
      e = nxt() & 32'h3;
      wr(cr(c, 2), 16'h0000);
      wr(cr(c, 2), 16'h0080 | m | 16'(e << 5));
      wr({`ICX_IDX_CFLG, 2'b00}, 16'h0000);
      pulse(c, 16);
      rd(cr(c, 2));
      chk("not_empty", rd_q[3], 1);
      chk("overflow", rd_q[4], caps(m, 16) > 4 && m != `ICX_M_EDGE);
      k = caps(m, 16) > 4 ? 4 : caps(m, 16);
      rd({`ICX_IDX_CFLG, 2'b00});
      chk("event flag", rd_q[c], k > e || m == `ICX_M_EDGE);
      for (j = 0; j < k; j++) begin
        rd(cr(c, 0));
        if (j > 0) chk("spacing", 16'(rd_q[15:0] - prev), step(m) * (slow ? 9 : 4));
        prev = rd_q[15:0];
        if (j == 1 && rd_q !== 32'h0 && m == `ICX_M_RISE) pulse(c, 1);
      end
      rd(cr(c, 2));
      chk("drained", rd_q[3], 0);
    end
    cpu_sleep <= 1'b1;
    rd({`ICX_IDX_TIMER_LOW_COUNT, 2'b00});
    prev = rd_q[15:0];
    repeat (20) @(posedge core_clk);
    rd({`ICX_IDX_TIMER_LOW_COUNT, 2'b00});
    chk("frozen count", rd_q[15:0], prev);
    c = nxt() & 32'h7;
    wr({`ICX_IDX_TCON2, 2'b00}, 16'h0000);
    wr({`ICX_IDX_CEN, 2'b00}, 16'h00FF);
    wr(cr(c, 2), 16'h0000);
    wr(cr(c, 2), 16'h0000 | `ICX_M_WAKE);
    wake_seen = 1'b0;
    pulse(c, 1);
    chk("wake", wake_seen, 1);
    chk("channel request", capture_irq_q[c], 1);
    cpu_sleep <= 1'b0;
    k = 16 + (nxt() & 32'h1F);
    wr({`ICX_IDX_TCON2, 2'b00}, 16'h0008);
    wr({`ICX_IDX_PR2, 2'b00}, 16'(k));
    wr({`ICX_IDX_PR3, 2'b00}, 16'h0000);
    wr({`ICX_IDX_HLD, 2'b00}, 16'h0000);
    wr({`ICX_IDX_TIMER_LOW_COUNT, 2'b00}, 16'h0000);
    wr({`ICX_IDX_INTERRUPT_ENABLE_CTRL_REG0, 2'b00}, 16'h0000);
    wr({`ICX_IDX_INTERRUPT_FLAG_STATUS_REG0, 2'b00}, 16'h0000);
    wr({`ICX_IDX_TCON2, 2'b00}, 16'h8008);
    repeat (2 * k + 20) @(posedge core_clk);
    rd({`ICX_IDX_INTERRUPT_FLAG_STATUS_REG0, 2'b00});
    chk("timebase flag", rd_q[7], 1);
    chk("masked request", timebase_irq_q, 0);
    wr({`ICX_IDX_INTERRUPT_ENABLE_CTRL_REG0, 2'b00}, 16'h0080);
    repeat (3) @(posedge core_clk);
    chk("enabled request", timebase_irq_q, 1);
    wr({`ICX_IDX_TCON2, 2'b00}, 16'h0000);
    wr({`ICX_IDX_INTERRUPT_FLAG_STATUS_REG0, 2'b00}, 16'h0000);
    repeat (3) @(posedge core_clk);
    chk("cleared request", timebase_irq_q, 0);
    // gated wide mode: a gate pulse far shorter than the period, so only its fall can flag
    wr({`ICX_IDX_TIMER_LOW_COUNT, 2'b00}, 16'h0000);
    wr({`ICX_IDX_TCON2, 2'b00}, 16'h8048);
    gate <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd({`ICX_IDX_INTERRUPT_FLAG_STATUS_REG0, 2'b00});
    chk("gate high flag", rd_q[7], 0);
    gate <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd({`ICX_IDX_INTERRUPT_FLAG_STATUS_REG0, 2'b00});
    chk("gate fall flag", rd_q[7], 1);
    wrap_up();
  end
endmodule
`default_nettype wire
